// ==== logic/sptc_defs.svh ====
// Register offsets, field positions, reset values and counts of the timer configuration bank
`ifndef SPTC_DEFS_SVH
`define SPTC_DEFS_SVH

`define SPTC_OFS_ACT      8'h30
`define SPTC_OFS_BASE_HI  8'h60
`define SPTC_OFS_BASE_LO  8'h61
`define SPTC_OFS_IRQ_SEL  8'h70
`define SPTC_OFS_IRQ_KIND 8'h71
`define SPTC_OFS_DMA_A    8'h74
`define SPTC_OFS_DMA_B    8'h75
`define SPTC_OFS_CFG      8'hF0
`define SPTC_OFS_STAT     8'hF1

`define SPTC_RST_ACT      8'h00
`define SPTC_RST_BASE_HI  8'h00
`define SPTC_RST_BASE_LO  8'h00
`define SPTC_RST_IRQ_SEL  8'h00
`define SPTC_RST_IRQ_KIND 8'h03
`define SPTC_VAL_DMA      8'h04
`define SPTC_RST_CFG      8'h02

`define SPTC_MASK_BASE_LO 8'hFC
`define SPTC_MASK_KIND_WR 8'h02
`define SPTC_MASK_CFG     8'h0F

`define SPTC_BIT_ACT      0
`define SPTC_BIT_TRI      0
`define SPTC_BIT_PWR      1
`define SPTC_BIT_PU       2
`define SPTC_BIT_PP       3
`define SPTC_IRQ_NUM_W    4
`define SPTC_BIT_WAKE     4

`define SPTC_SYNC_STAGES  3

`endif

// ==== logic/sptc_pkg.sv ====
// Types shared by the timer configuration bank
package sptc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sptc_bus_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        req;
  } sptc_rt_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sptc_pin_out_t;

  typedef struct packed {
    logic push_pull;
    logic pull_up;
    logic normal_pwr;
    logic tri_en;
  } sptc_cfg_t;

endpackage : sptc_pkg

// ==== logic/sptc_in_sync.sv ====
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "sptc_defs.svh"
module sptc_in_sync (
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  input  wire logic pin_i,
  input  wire logic rst_val,
  output logic      level_q
);
  import sptc_pkg::*;

  logic [`SPTC_SYNC_STAGES-1:0] sh_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // Start at the pin's idle high level so no false low follows reset
      sh_q <= '1;
    end else begin
      sh_q <= {sh_q[`SPTC_SYNC_STAGES-2:0], pin_i};
    end
  end

  // Level changes only once stages two and three agree
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      level_q <= 1'b1;
    end else if (sh_q[1] == sh_q[2]) begin
      level_q <= sh_q[2];
    end
  end

  logic unused_rst_val;
  assign unused_rst_val = rst_val;

endmodule : sptc_in_sync
`default_nettype wire

// ==== logic/sptc_pin_drv.sv ====
// Timeout pin driver: power forcing, buffer type and high-impedance control
`timescale 1ns/1ps
`default_nettype none
`include "sptc_defs.svh"
module sptc_pin_drv (
  input  wire logic          CORE_CLK,
  input  wire logic          RST_N,
  input  wire logic          tmo_n,
  input  wire logic          active,
  input  wire sptc_pkg::sptc_cfg_t     cfg,
  output var  sptc_pkg::sptc_pin_out_t pin_q
);
  import sptc_pkg::*;

  logic lvl;
  logic hiz;

  assign lvl = cfg.normal_pwr ? tmo_n : 1'b1;
  assign hiz = cfg.tri_en & ~active;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_q <= '{o: 1'b0, oe: 1'b0};
    end else if (hiz) begin
      pin_q <= '{o: 1'b0, oe: 1'b0};
    end else if (cfg.push_pull) begin
      pin_q <= '{o: lvl, oe: 1'b1};
    end else begin
      pin_q <= '{o: 1'b0, oe: ~lvl};
    end
  end

endmodule : sptc_pin_drv
`default_nettype wire

// ==== logic/sptc_top.sv ====
// Supervision timer configuration bank: registers, runtime gate, timer control, timeout pin
`timescale 1ns/1ps
`default_nettype none
`include "sptc_defs.svh"
module sptc_top (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  input  wire sptc_pkg::sptc_bus_req_t BUS_REQ,
  output logic [7:0]                BUS_RDATA,
  input  wire sptc_pkg::sptc_rt_req_t  RT_REQ,
  output logic                      RT_SEL,
  input  wire logic                 TMO_N,
  output logic                      TMR_CLK_EN,
  output logic                      TMR_RUN,
  output logic [3:0]                IRQ_NUM,
  output logic                      IRQ_WAKE_EN,
  output logic                      IRQ_LEVEL_MODE,
  output logic                      TMO_PIN_O,
  output logic                      TMO_PIN_OE,
  input  wire logic                 TMO_PIN_I,
  output logic                      TMO_PULLUP_EN
);
  import sptc_pkg::*;

  logic [7:0]    act_q;
  logic [7:0]    base_hi_q;
  logic [7:0]    base_lo_q;
  logic [7:0]    irq_sel_q;
  logic          kind_b1_q;
  logic [3:0]    cfg_q;
  logic          pin_lvl_q;
  sptc_cfg_t     cfg;
  sptc_pin_out_t pin_q;
  logic          active;
  logic [7:0]    rd_d;

  function automatic logic wr_hit(input sptc_bus_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction : wr_hit

  assign active = act_q[`SPTC_BIT_ACT];
  assign cfg = '{push_pull:  cfg_q[`SPTC_BIT_PP],
                 pull_up:    cfg_q[`SPTC_BIT_PU],
                 normal_pwr: cfg_q[`SPTC_BIT_PWR],
                 tri_en:     cfg_q[`SPTC_BIT_TRI]};

  // Activation register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_q <= `SPTC_RST_ACT;
    end else if (wr_hit(BUS_REQ, `SPTC_OFS_ACT)) begin
      act_q <= BUS_REQ.wdata;
    end
  end

  // Base address
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      base_hi_q <= `SPTC_RST_BASE_HI;
      base_lo_q <= `SPTC_RST_BASE_LO;
    end else begin
      if (wr_hit(BUS_REQ, `SPTC_OFS_BASE_HI)) begin
        base_hi_q <= BUS_REQ.wdata;
      end
      if (wr_hit(BUS_REQ, `SPTC_OFS_BASE_LO)) begin
        base_lo_q <= BUS_REQ.wdata & `SPTC_MASK_BASE_LO;
      end
    end
  end

  // Interrupt select and kind
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_sel_q <= `SPTC_RST_IRQ_SEL;
      kind_b1_q <= |(`SPTC_RST_IRQ_KIND & `SPTC_MASK_KIND_WR);
    end else begin
      if (wr_hit(BUS_REQ, `SPTC_OFS_IRQ_SEL)) begin
        irq_sel_q <= BUS_REQ.wdata;
      end
      if (wr_hit(BUS_REQ, `SPTC_OFS_IRQ_KIND)) begin
        kind_b1_q <= BUS_REQ.wdata[1];
      end
    end
  end

  // Timer configuration; writes allowed in any power mode
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= 4'(`SPTC_RST_CFG);
    end else if (wr_hit(BUS_REQ, `SPTC_OFS_CFG)) begin
      cfg_q <= 4'(BUS_REQ.wdata & `SPTC_MASK_CFG);
    end
  end

  // Read mux; data stands in the cycle after the strobe only
  always_comb begin
    rd_d = 8'h00;
    unique case (BUS_REQ.addr)
      `SPTC_OFS_ACT:      rd_d = act_q;
      `SPTC_OFS_BASE_HI:  rd_d = base_hi_q;
      `SPTC_OFS_BASE_LO:  rd_d = base_lo_q & `SPTC_MASK_BASE_LO;
      `SPTC_OFS_IRQ_SEL:  rd_d = irq_sel_q;
      `SPTC_OFS_IRQ_KIND: rd_d = (`SPTC_RST_IRQ_KIND & ~`SPTC_MASK_KIND_WR)
                                 | {6'h00, kind_b1_q, 1'b0};
      `SPTC_OFS_DMA_A:    rd_d = `SPTC_VAL_DMA;
      `SPTC_OFS_DMA_B:    rd_d = `SPTC_VAL_DMA;
      `SPTC_OFS_CFG:      rd_d = {4'h0, cfg_q};
      `SPTC_OFS_STAT:     rd_d = {4'h0, TMO_PIN_OE, pin_lvl_q, TMR_CLK_EN, TMR_RUN};
      default:            rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= 8'h00;
    end else if (BUS_REQ.rd) begin
      BUS_RDATA <= rd_d;
    end else begin
      BUS_RDATA <= 8'h00;
    end
  end

  // Runtime window decode, 4-byte aligned, gated by activation
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RT_SEL <= 1'b0;
    end else begin
      RT_SEL <= active && RT_REQ.req
                && (RT_REQ.addr[15:2] == {base_hi_q, base_lo_q[7:2]});
    end
  end

  // Timer clock and run control
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TMR_CLK_EN <= 1'b0;
      TMR_RUN    <= 1'b0;
    end else begin
      TMR_CLK_EN <= cfg.normal_pwr;
      TMR_RUN    <= cfg.normal_pwr & active;
    end
  end

  // Interrupt routing and pin pull-up
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_NUM        <= 4'h0;
      IRQ_WAKE_EN    <= 1'b0;
      IRQ_LEVEL_MODE <= 1'b1;
      TMO_PULLUP_EN  <= 1'b0;
    end else begin
      IRQ_NUM        <= irq_sel_q[`SPTC_IRQ_NUM_W-1:0];
      IRQ_WAKE_EN    <= irq_sel_q[`SPTC_BIT_WAKE];
      IRQ_LEVEL_MODE <= kind_b1_q;
      TMO_PULLUP_EN  <= cfg.pull_up;
    end
  end

  sptc_pin_drv u_pin_drv (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .tmo_n    (TMO_N),
    .active   (active),
    .cfg      (cfg),
    .pin_q    (pin_q)
  );

  assign TMO_PIN_O  = pin_q.o;
  assign TMO_PIN_OE = pin_q.oe;

  sptc_in_sync u_in_sync (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .pin_i    (TMO_PIN_I),
    .rst_val  (1'b1),
    .level_q  (pin_lvl_q)
  );

endmodule : sptc_top
`default_nettype wire

// ==== tb/sptc_top_assertions.sv ====
// Port checker of the timer configuration bank
`timescale 1ns/1ps
`default_nettype none
module sptc_chk (
  input wire logic                    CORE_CLK,
  input wire logic                    RST_N,
  input wire sptc_pkg::sptc_bus_req_t BUS_REQ,
  input wire logic [7:0]              BUS_RDATA,
  input wire sptc_pkg::sptc_rt_req_t  RT_REQ,
  input wire logic                    RT_SEL,
  input wire logic                    TMO_N,
  input wire logic                    TMR_CLK_EN,
  input wire logic                    TMR_RUN,
  input wire logic                    TMO_PIN_O,
  input wire logic                    TMO_PIN_OE,
  input wire logic                    TMO_PULLUP_EN
);
  import sptc_pkg::*;
  logic [3:0] cfg_q;
  logic       act_q;
  wire logic  hiz = cfg_q[0] & ~act_q;
  // Mirror of the configuration and activation bits
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= 4'h2;
      act_q <= 1'b0;
    end else if (BUS_REQ.wr) begin
      if (BUS_REQ.addr == 8'hF0) cfg_q <= BUS_REQ.wdata[3:0];
      if (BUS_REQ.addr == 8'h30) act_q <= BUS_REQ.wdata[0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  chk_rt_gate: assert property (RT_SEL |-> $past(act_q) && $past(RT_REQ.req))
    else $error("runtime hit while blocked");
  chk_clk_en: assert property ($past(RST_N) |-> TMR_CLK_EN == $past(cfg_q[1]))
    else $error("timer clock enable wrong");
  chk_run_state: assert property ($past(RST_N) |-> TMR_RUN == ($past(cfg_q[1]) && $past(act_q)))
    else $error("timer run wrong");
  chk_pull_up: assert property ($past(RST_N) |-> TMO_PULLUP_EN == $past(cfg_q[2]))
    else $error("pull-up enable wrong");
  chk_pin_hiz: assert property ($past(RST_N) && $past(hiz) |-> !TMO_PIN_OE)
    else $error("pin driven while floated");
  chk_push_pull: assert property ($past(RST_N) && $past(cfg_q[3]) && !$past(hiz)
    |-> TMO_PIN_OE && TMO_PIN_O == (!$past(cfg_q[1]) || $past(TMO_N)))
    else $error("push-pull drive wrong");
  chk_open_drain: assert property ($past(RST_N) && !$past(cfg_q[3]) && !$past(hiz)
    |-> !TMO_PIN_O && TMO_PIN_OE == ($past(cfg_q[1]) && !$past(TMO_N)))
    else $error("open-drain drive wrong");
  chk_kind_read: assert property ($past(BUS_REQ.rd) && $past(BUS_REQ.addr) == 8'h71
    |-> BUS_RDATA[7:2] == 6'h00 && BUS_RDATA[0])
    else $error("interrupt kind fixed bits wrong");
endmodule : sptc_chk
bind sptc_top sptc_chk sptc_chk_i (.CORE_CLK, .RST_N, .BUS_REQ, .BUS_RDATA, .RT_REQ,
  .RT_SEL, .TMO_N, .TMR_CLK_EN, .TMR_RUN, .TMO_PIN_O, .TMO_PIN_OE, .TMO_PULLUP_EN);
`default_nettype wire

// ==== tb/sptc_top_bench.sv ====
// Self-checking bench of the timer configuration bank
`timescale 1ns/1ps
`default_nettype none
module sptc_top_bench;
  import sptc_pkg::*;
  logic          CORE_CLK, RST_N, TMO_N, RT_SEL, TMR_CLK_EN, TMR_RUN, IRQ_WAKE_EN;
  logic          IRQ_LEVEL_MODE, TMO_PIN_O, TMO_PIN_OE, TMO_PULLUP_EN, TMO_PIN_I;
  sptc_bus_req_t BUS_REQ;
  sptc_rt_req_t  RT_REQ;
  logic [7:0]    BUS_RDATA, v, d;
  logic [3:0]    IRQ_NUM;
  logic [1:0]    p;
  logic [31:0]   lfsr = 32'hD5112912;
  int            fails, total_checks, cyc, i;
  logic [7:0]    adr [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0, 8'h55};
  logic [7:0]    rvl [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04, 8'h02, 8'h00};
  assign TMO_PIN_I = TMO_PIN_OE ? TMO_PIN_O : 1'b1;
  sptc_top sptc_top_i (.CORE_CLK, .RST_N, .BUS_REQ, .BUS_RDATA, .RT_REQ, .RT_SEL, .TMO_N,
    .TMR_CLK_EN, .TMR_RUN, .IRQ_NUM, .IRQ_WAKE_EN, .IRQ_LEVEL_MODE, .TMO_PIN_O,
    .TMO_PIN_OE, .TMO_PIN_I, .TMO_PULLUP_EN);
  initial begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Read-back value after writing w
  function automatic logic [7:0] rexp(logic [7:0] a, logic [7:0] w);
    case (a)
      8'h30, 8'h60, 8'h70: return w;
      8'h61: return w & 8'hFC;
      8'h71: return 8'h01 | (w & 8'h02);
      8'h74, 8'h75: return 8'h04;
      8'hF0: return w & 8'h0F;
      default: return 8'h00;
    endcase
  endfunction : rexp
  // Pin {enable, level} for cfg k[3:0], active k[4], timeout level k[5]
  function automatic logic [1:0] pexp(logic [5:0] k);
    logic l;
    l = k[1] ? k[5] : 1'b1;
    if (k[0] && !k[4]) return 2'b00;
    return k[3] ? {1'b1, l} : {!l, 1'b0};
  endfunction : pexp
  task automatic chk(logic [7:0] g, logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] w);
    BUS_REQ <= '{a, w, 1'b1, 1'b0};
    @(posedge CORE_CLK);
    BUS_REQ <= '0;
    @(posedge CORE_CLK);
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] r);
    BUS_REQ <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge CORE_CLK);
    BUS_REQ <= '0;
    #1 r = BUS_RDATA;
    @(posedge CORE_CLK);
  endtask : rd
  task automatic rt(logic [15:0] a, logic e);
    RT_REQ <= '{a, 1'b1};
    @(posedge CORE_CLK);
    RT_REQ <= '0;
    #1 chk(RT_SEL, e);
    @(posedge CORE_CLK);
  endtask : rt
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    BUS_REQ = '0;
    RT_REQ = '0;
    TMO_N = 1'b1;
    RST_N = 1'b0;
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    @(posedge CORE_CLK);
    for (int n = 0; n < 9; n++) begin
      rd(adr[n], v);
      chk(v, rvl[n]);
    end
    // All ones and all zeros first, then random values
    for (int n = 0; n < 58; n++) begin
      lfsr = nx(lfsr);
      i = (n < 18) ? n / 2 : int'(lfsr[3:0]) % 9;
      d = (n < 18) ? {8{n[0]}} ^ 8'hFF : lfsr[15:8];
      wr(adr[i], d);
      rd(adr[i], v);
      chk(v, rexp(adr[i], d));
    end
    wr(8'h60, 8'hA5);
    wr(8'h61, 8'h37);
    for (int a = 0; a < 2; a++) begin
      wr(8'h30, a[7:0]);
      for (int j = 0; j < 6; j++) rt(16'hA533 + j[15:0], a == 1 && j > 0 && j < 5);
    end
    wr(8'hF0, 8'h00);
    rt(16'hA536, 1'b1);
    rd(8'h61, v);
    chk(v, 8'h34);
    for (int k = 0; k < 64; k++) begin
      wr(8'hF0, {4'h0, k[3:0]});
      wr(8'h30, {7'h00, k[4]});
      TMO_N <= k[5];
      repeat (3) @(posedge CORE_CLK);
      #1 chk({TMO_PIN_OE, TMO_PIN_O}, pexp(k[5:0]));
      chk({TMR_CLK_EN, TMR_RUN, TMO_PULLUP_EN}, {k[1], k[1] & k[4], k[2]});
      p = pexp(k[5:0]);
      repeat (2) @(posedge CORE_CLK);
      rd(8'hF1, v);
      chk(v, {4'h0, p[1], (p[1] ? p[0] : 1'b1), k[1], k[1] & k[4]});
    end
    wr(8'h70, 8'h1A);
    wr(8'h71, 8'h00);
    repeat (3) @(posedge CORE_CLK);
    #1 chk({IRQ_WAKE_EN, IRQ_NUM}, 8'h1A);
    chk(IRQ_LEVEL_MODE, 1'b0);
    close_out;
  end
endmodule : sptc_top_bench
`default_nettype wire
